// ==== pkg/map_defs.svh ====
// Register offsets, field positions, reset values and barrier type codes for the access port.
// Assumes inclusion by bare name from the core and testbench files.
`ifndef MAP_DEFS_SVH
`define MAP_DEFS_SVH
`define OFS_ACW 8'h00
`define OFS_ADDR 8'h04
`define OFS_DRW 8'h0C
`define OFS_BARRIER 8'h20
`define ACW_SW_EN 31
`define ACW_B30 30
`define ACW_MSEL 29
`define ACW_ALLOC 28
`define ACW_SECURE_DEBUG_ENABLE 23
`define ACW_PEND 7
`define ACW_PEN 6
`define ACW_MODE_LO 8
`define ACW_INC_LO 4
`define PROT_RST_AXI 7'h30
`define PROT_RST_AHB 7'h43
`define PROT_RST_AHB5 7'h43
`define HPROT_ABSENT 4'h3
`define MODE_BAR_EN 4'h1
`define SIZE_RST 3'h2
`define BAR_MEMORY 2'h1
`define BAR_SYNC 2'h3
`endif

// ==== pkg/map_pkg.sv ====
// Types shared by the access port core and the testbench.
// Assumes map_defs.svh is on the include path.
`default_nettype none
package map_pkg;
	typedef enum logic [1:0] {
		VAR_AXI4 = 2'h0,
		VAR_AHB3 = 2'h1,
		VAR_AHB5 = 2'h2
	} variant_t;
	typedef struct packed {
		logic [6:0] prot_field;
		logic [4:0] hprot;
		logic hnonsec;
		logic master_self;
		logic [2:0] size;
	} mem_attr_t;
	typedef struct packed {
		logic req;
		logic write;
		logic [31:0] addr;
		logic [31:0] wdata;
	} mem_cmd_t;
endpackage
`default_nettype wire

// ==== core/barrier_seq.sv ====
// Barrier sequencer: holds the barrier type and runs one barrier handshake at a time.
// Assumes the memory side raises i_bar_done for one cycle when the barrier finishes.
`default_nettype none
`include "map_defs.svh"
module barrier_seq (
	input wire logic i_mclk,
	input wire logic i_reset_n,
	input wire logic i_ce,
	input wire logic i_start,
	input wire logic [1:0] i_type,
	input wire logic i_bar_done,
	output logic o_bar_req,
	output logic [1:0] o_bar_type,
	output logic o_idle
);
	typedef enum logic [0:0] {
		BS_IDLE = 1'b0,
		BS_BUSY = 1'b1
	} bar_state_t;
	bar_state_t state_q;

	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) begin
			state_q <= BS_IDLE;
			o_bar_req <= 1'b0;
			o_bar_type <= 2'h0;
			o_idle <= 1'b1;
		end else if (i_ce) begin
			case (state_q)
				BS_IDLE: begin
					if (i_start && (i_type == `BAR_MEMORY || i_type == `BAR_SYNC)) begin
						state_q <= BS_BUSY;
						o_bar_req <= 1'b1;
						o_bar_type <= i_type;
						o_idle <= 1'b0;
					end
				end
				BS_BUSY: begin
					if (i_bar_done) begin
						state_q <= BS_IDLE;
						o_bar_req <= 1'b0;
						o_idle <= 1'b1;
					end
				end
				default: begin
					state_q <= BS_IDLE;
					o_bar_req <= 1'b0;
					o_idle <= 1'b1;
				end
			endcase
		end
	end
endmodule
`default_nettype wire

// ==== core/mem_access_port.sv ====
// Memory access port core: control word, transfer address, data window and barrier register,
// turning control word settings into memory bus attributes for three bus flavours.
// Assumes one clock, synchronous inputs, and a memory side that pulses i_mem_done per transfer.
//
// Decided for this implementation: the register offsets and strobed register access.
`default_nettype none
`include "map_defs.svh"
module mem_access_port #(
	parameter map_pkg::variant_t VARIANT = map_pkg::VAR_AXI4,
	parameter bit BAR_MODE_WRITABLE = 1'b1,
	parameter int MAX_SIZE = 2,
	parameter bit HAS_MASTER_SEL = 1'b1,
	parameter bit HAS_ALLOC = 1'b1,
	parameter logic [3:0] HPROT_IMPL = 4'hF,
	parameter bit HAS_SECURE_DEBUG_ENABLE = 1'b1,
	parameter bit HAS_NONSEC = 1'b1,
	parameter bit HAS_PORT_EN = 1'b1
) (
	input wire logic i_mclk,
	input wire logic i_reset_n,
	input wire logic i_ce,
	input wire logic [7:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	input wire logic i_secure_debug_enable,
	input wire logic i_port_enable,
	output map_pkg::mem_cmd_t o_mem_cmd,
	output map_pkg::mem_attr_t o_mem_attr,
	input wire logic [31:0] i_mem_rdata,
	input wire logic i_mem_done,
	output logic o_bar_req,
	output logic [1:0] o_bar_type,
	input wire logic i_bar_done
);
	import map_pkg::*;

	localparam bit IS_AXI = (VARIANT == VAR_AXI4);
	localparam bit IS_AHB3 = (VARIANT == VAR_AHB3);
	localparam bit IS_AHB5 = (VARIANT == VAR_AHB5);
	localparam bit B30_RW = IS_AXI || IS_AHB3 || (IS_AHB5 && HAS_NONSEC);
	localparam bit B29_RW = IS_AXI || HAS_MASTER_SEL;
	localparam bit B28_RW = IS_AXI || (IS_AHB3 && HAS_ALLOC);
	localparam logic [3:0] LOW_RW = IS_AXI ? 4'hF : HPROT_IMPL;
	localparam bit MODE_RW = IS_AXI && BAR_MODE_WRITABLE;

	// Bits software can change; everything else is fixed or live status.
	localparam logic [31:0] RW_MASK = {1'b1, B30_RW, B29_RW, B28_RW, LOW_RW, 12'h000,
		{4{MODE_RW}}, 2'h0, 2'h3, 4'h7};

	// Constant bits: absent privileged/data read one, a fixed barrier mode reads 0001.
	localparam logic [3:0] LOW_FIX = IS_AXI ? 4'h0 : (~HPROT_IMPL & `HPROT_ABSENT);
	localparam logic [3:0] MODE_FIX = (IS_AXI && !BAR_MODE_WRITABLE) ? `MODE_BAR_EN : 4'h0;
	localparam logic [31:0] FIX_BITS = {4'h0, LOW_FIX, 12'h000, MODE_FIX, 8'h00};

	localparam logic [6:0] PROT_RST = IS_AXI ? `PROT_RST_AXI :
		(IS_AHB3 ? `PROT_RST_AHB : `PROT_RST_AHB5);
	localparam logic [31:0] ACW_RST = ({1'b0, PROT_RST, 20'h00000, 1'b0, `SIZE_RST}) & RW_MASK;

	initial begin
		if (MAX_SIZE < 2 || MAX_SIZE > 7) begin
			$error("MAX_SIZE must lie between 2 and 7");
		end
		if (!IS_AXI && MAX_SIZE != 2) begin
			$error("Only the coherent AXI4 variant may take sizes above a word");
		end
	end

	function automatic logic size_ok(input logic [2:0] sz);
		size_ok = (32'(sz) <= MAX_SIZE);
	endfunction

	function automatic logic [31:0] step_of(input logic [2:0] sz);
		step_of = 32'h1 << sz;
	endfunction

	logic [31:0] acw_q;
	logic [31:0] addr_q;
	logic [31:0] rdbuf_q;
	logic pending_q;
	logic secure_debug_enable_q;
	logic pen_q;
	logic bar_idle;
	logic [1:0] bar_sel_q;
	logic [31:0] acw_view;
	logic wr_acw;
	logic wr_addr;
	logic acc_drw;
	logic wr_bar;
	logic mode_bar_en;
	logic secure_block;
	logic can_issue;

	assign wr_acw = i_wr && (i_addr == `OFS_ACW);
	assign wr_addr = i_wr && (i_addr == `OFS_ADDR);
	assign acc_drw = (i_wr || i_rd) && (i_addr == `OFS_DRW);
	assign wr_bar = i_wr && (i_addr == `OFS_BARRIER);

	always_comb begin
		acw_view = (acw_q & RW_MASK) | FIX_BITS;
		acw_view[`ACW_SECURE_DEBUG_ENABLE] = secure_debug_enable_q;
		acw_view[`ACW_PEND] = pending_q;
		acw_view[`ACW_PEN] = pen_q;
	end

	assign mode_bar_en = (acw_view[`ACW_MODE_LO +: 4] == `MODE_BAR_EN);
	// A secure request without secure debug enabled issues nothing on AXI4.
	assign secure_block = IS_AXI && !acw_view[`ACW_MSEL] && !secure_debug_enable_q;
	assign can_issue = pen_q && !pending_q && !secure_block;

	// Live inputs are registered once so the status bits read as flip-flops.
	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) begin
			secure_debug_enable_q <= 1'b0;
			pen_q <= 1'b0;
		end else if (i_ce) begin
			secure_debug_enable_q <= HAS_SECURE_DEBUG_ENABLE && (IS_AXI || IS_AHB3 || IS_AHB5) && i_secure_debug_enable;
			pen_q <= HAS_PORT_EN ? i_port_enable : 1'b1;
		end
	end

	// Control word: masked store; an unsupported size leaves the old size in place.
	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) begin
			acw_q <= ACW_RST;
		end else if (i_ce && wr_acw) begin
			acw_q[31:3] <= i_wdata[31:3] & RW_MASK[31:3];
			if (size_ok(i_wdata[2:0])) begin
				acw_q[2:0] <= i_wdata[2:0];
			end
		end
	end

	// Transfer address, with auto increment by the transfer size after each issued transfer.
	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) begin
			addr_q <= 32'h0000_0000;
		end else if (i_ce) begin
			if (wr_addr) begin
				addr_q <= i_wdata;
			end else if (acc_drw && can_issue && acw_view[`ACW_INC_LO +: 2] != 2'h0) begin
				addr_q <= addr_q + step_of(acw_view[2:0]);
			end
		end
	end

	// Memory command and attributes are captured together at transfer start.
	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) begin
			o_mem_cmd <= '0;
			o_mem_attr <= '0;
			pending_q <= 1'b0;
		end else if (i_ce) begin
			if (pending_q) begin
				if (i_mem_done) begin
					o_mem_cmd.req <= 1'b0;
					pending_q <= 1'b0;
				end
			end else if (acc_drw && can_issue) begin
				pending_q <= 1'b1;
				o_mem_cmd.req <= 1'b1;
				o_mem_cmd.write <= i_wr;
				o_mem_cmd.addr <= addr_q;
				o_mem_cmd.wdata <= i_wdata;
				o_mem_attr.prot_field <= acw_view[30:24];
				o_mem_attr.hprot <= acw_view[28:24];
				o_mem_attr.hnonsec <= IS_AHB5 && acw_view[`ACW_B30];
				o_mem_attr.master_self <= acw_view[`ACW_MSEL] || !HAS_MASTER_SEL;
				o_mem_attr.size <= acw_view[2:0];
			end
		end
	end

	// Read data of the last completed read, returned by the next data window read.
	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) begin
			rdbuf_q <= 32'h0000_0000;
		end else if (i_ce && pending_q && i_mem_done && !o_mem_cmd.write) begin
			rdbuf_q <= i_mem_rdata;
		end
	end

	// Barrier type field is kept for read back; only legal when barrier mode is enabled.
	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) begin
			bar_sel_q <= 2'h0;
		end else if (i_ce && wr_bar && IS_AXI && mode_bar_en && bar_idle) begin
			bar_sel_q <= i_wdata[2:1];
		end
	end

	barrier_seq u_barrier (
		.i_mclk(i_mclk),
		.i_reset_n(i_reset_n),
		.i_ce(i_ce),
		.i_start(wr_bar && IS_AXI && mode_bar_en && i_wdata[0]),
		.i_type(i_wdata[2:1]),
		.i_bar_done(i_bar_done),
		.o_bar_req(o_bar_req),
		.o_bar_type(o_bar_type),
		.o_idle(bar_idle)
	);

	// Read port: data stands in the cycle after the read strobe; unmapped reads give zero.
	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) begin
			o_rdata <= 32'h0000_0000;
		end else if (i_ce) begin
			if (i_rd) begin
				case (i_addr)
					`OFS_ACW: o_rdata <= acw_view;
					`OFS_ADDR: o_rdata <= addr_q;
					`OFS_DRW: o_rdata <= rdbuf_q;
					`OFS_BARRIER: o_rdata <= IS_AXI ? {29'h0, bar_sel_q, bar_idle} : 32'h0;
					default: o_rdata <= 32'h0000_0000;
				endcase
			end else begin
				o_rdata <= 32'h0000_0000;
			end
		end
	end
endmodule
`default_nettype wire

// ==== testbench/map_assertions.sv ====
// Checker for the access port's memory and barrier handshakes.
// Assumes it is bound to mem_access_port with the clock enable held high.
`default_nettype none
`include "map_defs.svh"
module map_checker #(
	parameter int MAX_SIZE = 2
) (
	input wire logic i_mclk,
	input wire logic i_reset_n,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [7:0] i_addr,
	input wire logic i_port_enable,
	input wire map_pkg::mem_cmd_t o_mem_cmd,
	input wire map_pkg::mem_attr_t o_mem_attr,
	input wire logic i_mem_done,
	input wire logic o_bar_req,
	input wire logic [1:0] o_bar_type,
	input wire logic i_bar_done
);
	timeunit 1ns;
	timeprecision 1ps;
	logic drw_q;
	logic bar_wr_q;
	// A request may only rise after a matching strobe, so the strobes are delayed by one cycle.
	always_ff @(posedge i_mclk) begin
		drw_q <= (i_wr || i_rd) && i_addr == `OFS_DRW;
		bar_wr_q <= i_wr && i_addr == `OFS_BARRIER;
	end
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_reset_n);
	a_bar_hold: assert property (o_bar_req && !i_bar_done |=> o_bar_req && $stable(o_bar_type))
		else $error("Barrier request dropped early.");
	a_bar_drop: assert property (o_bar_req && i_bar_done |=> !o_bar_req)
		else $error("Barrier request outlived its done pulse.");
	a_bar_type_legal: assert property (o_bar_req |-> o_bar_type == 2'h1 || o_bar_type == 2'h3)
		else $error("Reserved barrier type issued.");
	a_bar_cause: assert property ($rose(o_bar_req) |-> bar_wr_q)
		else $error("Barrier raised without a barrier write.");
	a_attr_stable: assert property (o_mem_cmd.req && !i_mem_done |=> $stable(o_mem_cmd) && $stable(o_mem_attr))
		else $error("Transfer attributes changed mid transfer.");
	a_req_drop: assert property (o_mem_cmd.req && i_mem_done |=> !o_mem_cmd.req)
		else $error("Transfer request outlived its done pulse.");
	a_req_cause: assert property ($rose(o_mem_cmd.req) |-> drw_q)
		else $error("Transfer started without a data access.");
	a_size_legal: assert property (o_mem_cmd.req |-> int'(o_mem_attr.size) <= MAX_SIZE)
		else $error("Transfer size above the supported maximum.");
	a_disabled_drop: assert property (drw_q && !$past(o_mem_cmd.req) && !$past(i_port_enable, 2) |-> !o_mem_cmd.req)
		else $error("Transfer issued while the port was disabled.");
	cover property (o_bar_req && i_bar_done);
	cover property (o_mem_cmd.req && i_mem_done && o_mem_cmd.write);
	cover property (o_mem_cmd.req && i_mem_done && !o_mem_cmd.write);
endmodule
`default_nettype wire

// ==== testbench/mem_side_model.sv ====
// Memory-side partner: ends each transfer and barrier after a short or a long wait.
// Assumes the port holds its requests until it sees the done pulse.
`default_nettype none
module mem_side_model (
	input wire logic i_mclk,
	input wire logic i_reset_n,
	input wire logic i_slow,
	input wire map_pkg::mem_cmd_t i_cmd,
	input wire logic i_bar_req,
	output logic o_done,
	output logic o_bar_done,
	output logic [31:0] o_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] wait_q;
	logic hit;
	assign hit = wait_q == (i_slow ? 4'h6 : 4'h1);
	always_ff @(posedge i_mclk) begin
		if (!i_reset_n || o_done || o_bar_done || !(i_cmd.req || i_bar_req)) begin
			wait_q <= 4'h0;
		end else begin
			wait_q <= wait_q + 4'h1;
		end
	end
	// Read data is valid only beside done; elsewhere it toggles so a stale capture cannot match.
	always_ff @(posedge i_mclk) begin
		o_done <= i_reset_n && i_cmd.req && hit;
		o_bar_done <= i_reset_n && i_bar_req && hit;
		o_rdata <= (i_cmd.req && hit) ? ~i_cmd.addr : {o_rdata[30:0], ~o_rdata[31]};
	end
endmodule
`default_nettype wire

// ==== testbench/test_mem_access_port.sv ====
// Testbench for the coherent AXI4 access port with a writable barrier-enable mode.
// Assumes the memory-side model in mem_side_model.sv and the checker bound below.
`default_nettype none
`include "map_defs.svh"
module test_mem_access_port;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_mclk = 1'b0;
	logic i_reset_n = 1'b0;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic [7:0] i_addr = 8'h00;
	logic [31:0] i_wdata = 32'h0;
	logic secure_debug_enable = 1'b1;
	logic port_en = 1'b1;
	logic slow = 1'b0;
	logic ce = 1'b1;
	logic [31:0] o_rdata;
	logic [31:0] mem_rdata;
	logic mem_done;
	logic o_bar_req;
	logic [1:0] o_bar_type;
	logic bar_done;
	map_pkg::mem_cmd_t o_mem_cmd;
	map_pkg::mem_attr_t o_mem_attr;
	int err_count = 0;
	int checks = 0;
	int cyc = 0;
	mem_access_port dut (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_ce(ce), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_secure_debug_enable(secure_debug_enable), .i_port_enable(port_en),
		.o_mem_cmd(o_mem_cmd), .o_mem_attr(o_mem_attr), .i_mem_rdata(mem_rdata), .i_mem_done(mem_done),
		.o_bar_req(o_bar_req), .o_bar_type(o_bar_type), .i_bar_done(bar_done));
	mem_side_model far (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_slow(slow), .i_cmd(o_mem_cmd),
		.i_bar_req(o_bar_req), .o_done(mem_done), .o_bar_done(bar_done), .o_rdata(mem_rdata));
	task automatic summarize;
		if (err_count == 0 && checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("Error at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_mclk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_mclk);
		i_wr <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge i_mclk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_mclk);
		i_rd <= 1'b0;
		#1;
		chk(o_rdata, exp);
	endtask
	// Bounded wait for the memory and barrier handshakes to finish.
	task automatic wait_idle;
		int n;
		n = 0;
		while ((o_mem_cmd.req || o_bar_req) && n < 50) begin
			@(posedge i_mclk);
			#1;
			n++;
		end
		if (n == 50) begin
			err_count++;
		end
	endtask
	initial begin
		forever #2.5 i_mclk = ~i_mclk;
	end
	always @(posedge i_mclk) begin
		cyc++;
		if (cyc == 3000) begin
			err_count++;
			summarize();
		end
	end
	initial begin
		repeat (3) @(posedge i_mclk);
		i_reset_n <= 1'b1;
		rd(`OFS_ACW, 32'h30800042);
		rd(`OFS_BARRIER, 32'h1);
		wr(`OFS_BARRIER, 32'h7);
		chk({31'h0, o_bar_req}, 32'h0);
		wr(`OFS_ACW, 32'h30000102);
		rd(`OFS_ACW, 32'h30800142);
		wr(`OFS_BARRIER, 32'h5);
		chk({31'h0, o_bar_req}, 32'h0);
		wr(`OFS_BARRIER, 32'h6);
		chk({31'h0, o_bar_req}, 32'h0);
		slow <= 1'b1;
		for (int t = 1; t < 4; t += 2) begin
			wr(`OFS_BARRIER, 32'(t * 2 + 1));
			chk({29'h0, o_bar_req, o_bar_type}, 32'(4 + t));
			rd(`OFS_BARRIER, 32'(t * 2));
			wait_idle();
			rd(`OFS_BARRIER, 32'(t * 2 + 1));
		end
		wr(`OFS_ACW, 32'h30000100);
		rd(`OFS_ACW, 32'h30800140);
		wr(`OFS_ACW, 32'h30000103);
		rd(`OFS_ACW, 32'h30800140);
		wr(`OFS_ACW, 32'h30000112);
		wr(`OFS_ADDR, 32'h100);
		wr(`OFS_DRW, 32'hCAFE0000);
		chk({20'h0, o_mem_cmd.req, o_mem_cmd.write, o_mem_attr.prot_field, o_mem_attr.size}, 32'hD82);
		chk({25'h0, o_mem_attr.hprot, o_mem_attr.hnonsec, o_mem_attr.master_self}, 32'h41);
		chk(o_mem_cmd.addr ^ o_mem_cmd.wdata, 32'hCAFE0100);
		rd(`OFS_ACW, 32'h308001D2);
		wait_idle();
		rd(`OFS_ACW, 32'h30800152);
		rd(`OFS_ADDR, 32'h104);
		@(posedge i_mclk);
		port_en <= 1'b0;
		rd(`OFS_ACW, 32'h30800112);
		rd(`OFS_DRW, 32'h0);
		chk({31'h0, o_mem_cmd.req}, 32'h0);
		port_en <= 1'b1;
		slow <= 1'b0;
		rd(`OFS_DRW, 32'h0);
		wait_idle();
		rd(`OFS_DRW, 32'hFFFFFEFB);
		wait_idle();
		// A write made while the clock enable is low must leave the control word untouched.
		ce <= 1'b0;
		wr(`OFS_ACW, 32'h00000000);
		ce <= 1'b1;
		rd(`OFS_ACW, 32'h30800152);
		rd(8'h40, 32'h0);
		summarize();
	end
endmodule
bind mem_access_port map_checker #(.MAX_SIZE(MAX_SIZE)) u_chk (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_wr(i_wr),
	.i_rd(i_rd), .i_addr(i_addr), .i_port_enable(i_port_enable), .o_mem_cmd(o_mem_cmd), .o_mem_attr(o_mem_attr),
	.i_mem_done(i_mem_done), .o_bar_req(o_bar_req), .o_bar_type(o_bar_type), .i_bar_done(i_bar_done));
`default_nettype wire
